// *** wiper_pkg.sv ***
// What this block does
// - Target only; never drives clock; 7-bit address
// - Works at 100 kb/s and 400 kb/s
// - Data falls, clock high: start new transfer
// - Data changes only while clock low
// - Acknowledge low on ninth clock after byte
// - Address mismatch: leave data high, no acknowledge
// - Bus collision resets the interface
// - Repeated start continues with same master
// - Data rises, clock high: stop ends transfer
// - Stop resets interface, wait for start
// - Never stretch the clock
// - Malformed transfer abandoned without effect
// - Stray start or stop aborts before write
// - Glitch filter on clock and data inputs
// - Lines only pulled low or released
// - General call gets no acknowledge
// - Seven fixed address bits plus direction bit
// - Seven-bit wiper; data MSB ignored
// - After bad command, release and ignore bus
`default_nettype none
package wiper_pkg;
  localparam int        CLK_MHZ     = 100;
  localparam int        SPIKE_NS    = 50;
  // Least time, so round up; never below one cycle
  localparam int        FILT_CYC    = (SPIKE_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
                                      (SPIKE_NS * CLK_MHZ + 999) / 1000;
  localparam int        FILT_W      = 3;
  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYC - 1);
  localparam int        CNT_W       = 4;
  localparam logic [CNT_W-1:0] BYTE_BITS = 4'h8;
  localparam logic [6:0] TARGET_ADDR = 7'h2f;
  localparam logic [6:0] GCALL_ADDR  = 7'h00;
  localparam logic [6:0] WIPER_RST   = 7'h40;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WRITE,
    ST_WRITE_ACK,
    ST_READ,
    ST_READ_ACK,
    ST_IGNORE
  } st_t;
endpackage : wiper_pkg
`default_nettype wire

// *** pin_filter.sv ***
`default_nettype none
module pin_filter (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      level
);
  logic                          meta_q, meta_d;
  logic                          sync_q, sync_d;
  logic                          lvl_q,  lvl_d;
  logic [wiper_pkg::FILT_W-1:0]  cnt_q,  cnt_d;

  ////////////////////////////////////////////////////////////////////////////
  // Two flops, then a level must hold FILT_CYC cycles before it is believed
  always_comb begin
    meta_d = pin;
    sync_d = meta_q;
    lvl_d  = lvl_q;
    cnt_d  = '0;
    if (sync_q != lvl_q) begin
      if (cnt_q == wiper_pkg::FILT_LAST) begin
        lvl_d = sync_q;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // Idle bus is high, so reset to high to avoid a false start
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      lvl_q  <= 1'b1;
      cnt_q  <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      lvl_q  <= lvl_d;
      cnt_q  <= cnt_d;
    end
  end

  assign level = lvl_q;

  ////////////////////////////////////////////////////////////////////////////
  glitch_filter_a:
    assert property (@(posedge clk) disable iff (!resetn)
      $changed(lvl_q) |-> ($past(cnt_q) == wiper_pkg::FILT_LAST) && ($past(sync_q) == lvl_q))
    else $error("Filtered level changed without a full stable run");
endmodule : pin_filter
`default_nettype wire

// *** bus_events.sv ***
`default_nettype none
module bus_events (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);
  logic scl_q, scl_d;
  logic sda_q, sda_d;

  always_comb begin
    scl_d = scl;
    sda_d = sda;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conditions need the clock high on both samples around the data edge
  assign scl_rise  = scl & ~scl_q;
  assign scl_fall  = ~scl & scl_q;
  assign start_det = scl & scl_q & sda_q & ~sda;
  assign stop_det  = scl & scl_q & ~sda_q & sda;

  ////////////////////////////////////////////////////////////////////////////
  start_form_a:
    assert property (@(posedge clk) disable iff (!resetn)
      start_det |-> scl && $past(scl) && $fell(sda))
    else $error("Start flagged without data fall under high clock");
endmodule : bus_events
`default_nettype wire

// *** wiper_port.sv ***
`default_nettype none
module wiper_port (
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic       SCL_I,
  output logic            SCL_O,
  output logic            SCL_OE,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE,
  output logic [6:0]      WIPER,
  output logic            WIPER_WR
);
  logic                          scl_f, sda_f;
  logic                          scl_rise, scl_fall, start_det, stop_det;
  wiper_pkg::st_t                st_q,  st_d;
  logic [wiper_pkg::CNT_W-1:0]   cnt_q, cnt_d;
  logic [7:0]                    sh_q,  sh_d;
  logic [7:0]                    tx_q,  tx_d;
  logic [6:0]                    wip_q, wip_d;
  logic                          wr_q,  wr_d;
  logic                          oe_q,  oe_d;
  logic                          coll;
  logic                          evt_q, evt_d;

  ////////////////////////////////////////////////////////////////////////////
  pin_filter u_scl_filt (
    .clk    (CLK),
    .resetn (RESETN),
    .pin    (SCL_I),
    .level  (scl_f)
  );

  pin_filter u_sda_filt (
    .clk    (CLK),
    .resetn (RESETN),
    .pin    (SDA_I),
    .level  (sda_f)
  );

  bus_events u_events (
    .clk       (CLK),
    .resetn    (RESETN),
    .scl       (scl_f),
    .sda       (sda_f),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command state machine; start beats stop beats bit events
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    sh_d  = sh_q;
    tx_d  = tx_q;
    wip_d = wip_q;
    wr_d  = 1'b0;
    coll  = 1'b0;
    if (start_det) begin
      st_d  = wiper_pkg::ST_ADDR;
      cnt_d = '0;
    end else if (stop_det) begin
      st_d  = wiper_pkg::ST_IDLE;
      cnt_d = '0;
    end else begin
      unique case (st_q)
        wiper_pkg::ST_IDLE, wiper_pkg::ST_IGNORE: begin
          // Everything but a start or stop is ignored here
          st_d = st_q;
        end
        wiper_pkg::ST_ADDR: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_f};
            cnt_d = cnt_q + 1'b1;
          end else if (scl_fall && cnt_q == wiper_pkg::BYTE_BITS) begin
            cnt_d = '0;
            // General call never matches the fixed address
            if (sh_q[7:1] == wiper_pkg::TARGET_ADDR) begin
              st_d = wiper_pkg::ST_ADDR_ACK;
            end else begin
              st_d = wiper_pkg::ST_IGNORE;
            end
          end
        end
        wiper_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (sh_q[0]) begin
              st_d = wiper_pkg::ST_READ;
              tx_d = {1'b0, wip_q};
            end else begin
              st_d = wiper_pkg::ST_WRITE;
            end
          end
        end
        wiper_pkg::ST_WRITE: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_f};
            cnt_d = cnt_q + 1'b1;
          end else if (scl_fall && cnt_q == wiper_pkg::BYTE_BITS) begin
            // Only a whole byte reaches the wiper; a stray condition before this aborts
            wip_d = sh_q[6:0];
            wr_d  = 1'b1;
            cnt_d = '0;
            st_d  = wiper_pkg::ST_WRITE_ACK;
          end
        end
        wiper_pkg::ST_WRITE_ACK: begin
          if (scl_fall) begin
            st_d = wiper_pkg::ST_WRITE;
          end
        end
        wiper_pkg::ST_READ: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 1'b1;
            if (tx_q[7] && !sda_f) begin
              coll = 1'b1;
              st_d = wiper_pkg::ST_IGNORE;
            end
          end else if (scl_fall) begin
            if (cnt_q == wiper_pkg::BYTE_BITS) begin
              cnt_d = '0;
              st_d  = wiper_pkg::ST_READ_ACK;
            end else begin
              tx_d = {tx_q[6:0], 1'b0};
            end
          end
        end
        wiper_pkg::ST_READ_ACK: begin
          if (scl_rise && sda_f) begin
            st_d = wiper_pkg::ST_IGNORE;
          end else if (scl_fall) begin
            // Read data is the wiper itself, ready at once, so no stretching
            st_d = wiper_pkg::ST_READ;
            tx_d = {1'b0, wip_q};
          end
        end
      endcase
    end
    // Data pin is only pulled low, and moves only on a clock fall
    oe_d = (st_d == wiper_pkg::ST_ADDR_ACK) || (st_d == wiper_pkg::ST_WRITE_ACK) ||
           ((st_d == wiper_pkg::ST_READ) && !tx_d[7]);
    evt_d = scl_fall | start_det | stop_det | coll;
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      st_q  <= wiper_pkg::ST_IDLE;
      cnt_q <= '0;
      sh_q  <= '0;
      tx_q  <= '0;
      wip_q <= wiper_pkg::WIPER_RST;
      wr_q  <= 1'b0;
      oe_q  <= 1'b0;
      evt_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
      tx_q  <= tx_d;
      wip_q <= wip_d;
      wr_q  <= wr_d;
      oe_q  <= oe_d;
      evt_q <= evt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock pin is input only; data pin drives a constant low
  assign SCL_O    = 1'b0;
  assign SCL_OE   = 1'b0;
  assign SDA_O    = 1'b0;
  assign SDA_OE   = oe_q;
  assign WIPER    = wip_q;
  assign WIPER_WR = wr_q;

  ////////////////////////////////////////////////////////////////////////////
  clock_released_a:
    assert property (@(posedge CLK) disable iff (!RESETN)
      !SCL_OE && !SDA_O)
    else $error("Clock driven or data driven high");

  start_restart_a:
    assert property (@(posedge CLK) disable iff (!RESETN)
      start_det |=> (st_q == wiper_pkg::ST_ADDR) && (cnt_q == '0) && !SDA_OE)
    else $error("Start did not restart address phase");

  stop_reset_a:
    assert property (@(posedge CLK) disable iff (!RESETN)
      stop_det && !start_det |=> (st_q == wiper_pkg::ST_IDLE) && !SDA_OE)
    else $error("Stop did not reset interface");

  addr_ack_a:
    assert property (@(posedge CLK) disable iff (!RESETN)
      (st_q == wiper_pkg::ST_ADDR) && scl_fall && !start_det && !stop_det &&
      (cnt_q == wiper_pkg::BYTE_BITS) && (sh_q[7:1] == wiper_pkg::TARGET_ADDR)
      |=> SDA_OE [*2])
    else $error("Matching address not acknowledged");

  addr_nack_a:
    assert property (@(posedge CLK) disable iff (!RESETN)
      (st_q == wiper_pkg::ST_ADDR) && scl_fall && !start_det && !stop_det &&
      (cnt_q == wiper_pkg::BYTE_BITS) && (sh_q[7:1] != wiper_pkg::TARGET_ADDR)
      |=> (st_q == wiper_pkg::ST_IGNORE) && !SDA_OE)
    else $error("Foreign address acknowledged");

  gcall_nack_a:
    assert property (@(posedge CLK) disable iff (!RESETN)
      (st_q == wiper_pkg::ST_ADDR) && scl_fall && !start_det && !stop_det &&
      (cnt_q == wiper_pkg::BYTE_BITS) && (sh_q[7:1] == wiper_pkg::GCALL_ADDR)
      |=> !SDA_OE)
    else $error("General call acknowledged");

  ignore_hold_a:
    assert property (@(posedge CLK) disable iff (!RESETN)
      (st_q == wiper_pkg::ST_IGNORE) && !start_det |=>
      ((st_q == wiper_pkg::ST_IGNORE) || (st_q == wiper_pkg::ST_IDLE)) && !SDA_OE)
    else $error("Left ignore state without start");

  wiper_data_a:
    assert property (@(posedge CLK) disable iff (!RESETN)
      WIPER_WR |-> (WIPER == $past(sh_q[6:0], 1)) && $past(st_q, 1) == wiper_pkg::ST_WRITE)
    else $error("Wiper not loaded from low seven bits");

  wiper_abort_a:
    assert property (@(posedge CLK) disable iff (!RESETN)
      (st_q == wiper_pkg::ST_WRITE) && (start_det || stop_det) |=> !WIPER_WR && $stable(WIPER))
    else $error("Aborted byte reached the wiper");

  wiper_stable_a:
    assert property (@(posedge CLK) disable iff (!RESETN)
      !WIPER_WR |-> $stable(WIPER))
    else $error("Wiper changed without a write");

  collision_reset_a:
    assert property (@(posedge CLK) disable iff (!RESETN)
      (st_q == wiper_pkg::ST_READ) && scl_rise && tx_q[7] && !sda_f && !start_det && !stop_det
      |=> (st_q == wiper_pkg::ST_IGNORE) ##1 !SDA_OE)
    else $error("Collision did not reset interface");

  sda_timing_a:
    assert property (@(posedge CLK) disable iff (!RESETN)
      $changed(SDA_OE) |-> evt_q)
    else $error("Data drive changed outside a clock fall or condition");
endmodule : wiper_port
`default_nettype wire

// *** bus_master_model.sv ***
`default_nettype none
module bus_master_model (
  input  wire logic sda,
  output logic      scl_oe,
  output logic      sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // Quarter bit time; the bench changes it to switch the bit rate
  realtime q_ns = 625.0;

  // Enables only pull low; a released line reads high via the pull-up
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data falls while clock high; also used as repeated start
  task automatic start_c();
    sda_oe = 1'b0;
    #(q_ns);
    scl_oe = 1'b0;
    #(2 * q_ns);
    sda_oe = 1'b1;
    #(2 * q_ns);
    scl_oe = 1'b1;
    #(q_ns);
  endtask : start_c

  // Data rises while clock high
  task automatic stop_c();
    sda_oe = 1'b1;
    #(q_ns);
    scl_oe = 1'b0;
    #(2 * q_ns);
    sda_oe = 1'b0;
    #(2 * q_ns);
  endtask : stop_c

  // Data moves only in the low phase, sampled mid high phase
  task automatic clk_bit(input logic b, output logic seen);
    sda_oe = ~b;
    #(q_ns);
    scl_oe = 1'b0;
    #(q_ns);
    seen = sda;
    #(q_ns);
    scl_oe = 1'b1;
    #(q_ns);
  endtask : clk_bit

  // Eight bits MSB first, then the ninth bit driven as mk
  task automatic xfer(input logic [7:0] d, input logic mk, output logic [7:0] g,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], g[i]);
    end
    clk_bit(mk, ack);
  endtask : xfer

  // Clock pulse shorter than the filter span, inside a low phase
  task automatic spike_scl();
    scl_oe = 1'b0;
    #30;
    scl_oe = 1'b1;
    #(q_ns);
  endtask : spike_scl
endmodule : bus_master_model
`default_nettype wire

// *** i2c_slave_wiper_port_bench.sv ***
`default_nettype none
module i2c_slave_wiper_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       CLK;
  logic       RESETN;
  logic       SCL_O, SCL_OE, SDA_O, SDA_OE, WIPER_WR;
  logic [6:0] WIPER;
  logic       m_scl_oe, m_sda_oe;
  wire        scl_w;
  wire        sda_w;
  int         err_total = 0;
  int         cmp_count = 0;
  int         wr_pulses = 0;

  assign scl_w = ~(m_scl_oe | SCL_OE);
  assign sda_w = ~(m_sda_oe | SDA_OE);

  wiper_port u_wiper_port (.CLK(CLK), .RESETN(RESETN), .SCL_I(scl_w), .SCL_O(SCL_O),
    .SCL_OE(SCL_OE), .SDA_I(sda_w), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .WIPER(WIPER),
    .WIPER_WR(WIPER_WR));
  bus_master_model u_bus_master_model (.sda(sda_w), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic summarize();
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    if (WIPER_WR === 1'b1) wr_pulses++;
    if (RESETN === 1'b1) begin
      chk("pin drive", 8'h00, {5'h00, SCL_O, SCL_OE, SDA_OE & SDA_O});
    end
  end

  // Byte with master releasing the ninth bit; checks the device answer
  task automatic put_byte(input logic [7:0] d, input logic e_ack, input string nm);
    logic [7:0] g;
    logic       a;
    u_bus_master_model.xfer(d, 1'b1, g, a);
    chk(nm, {7'h00, e_ack}, {7'h00, a});
  endtask : put_byte

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_write(input logic [7:0] d);
    int n0;
    n0 = wr_pulses;
    u_bus_master_model.start_c();
    put_byte({wiper_pkg::TARGET_ADDR, 1'b0}, 1'b0, "addr ack");
    put_byte(d, 1'b0, "data ack");
    u_bus_master_model.stop_c();
    chk("wiper", {1'b0, d[6:0]}, {1'b0, WIPER});
    chk("write pulses", 8'h01, 8'(wr_pulses - n0));
  endtask : t_write

  // Write then read back after a repeated start, no stop between
  task automatic t_restart(input logic [7:0] d);
    logic [7:0] g;
    logic       a;
    u_bus_master_model.start_c();
    put_byte({wiper_pkg::TARGET_ADDR, 1'b0}, 1'b0, "addr ack");
    put_byte(8'h00, 1'b0, "data ack");
    put_byte(d, 1'b0, "second data ack");
    u_bus_master_model.start_c();
    put_byte({wiper_pkg::TARGET_ADDR, 1'b1}, 1'b0, "read addr ack");
    u_bus_master_model.xfer(8'hff, 1'b0, g, a);
    chk("read data", {1'b0, d[6:0]}, g);
    u_bus_master_model.xfer(8'hff, 1'b1, g, a);
    chk("second read data", {1'b0, d[6:0]}, g);
    u_bus_master_model.stop_c();
  endtask : t_restart

  // Foreign and general call addresses, then a byte that must be ignored
  task automatic t_nack();
    logic [6:0] adr [2];
    logic [6:0] w0;
    adr = '{7'h2e, wiper_pkg::GCALL_ADDR};
    w0 = WIPER;
    foreach (adr[i]) begin
      u_bus_master_model.start_c();
      put_byte({adr[i], 1'b0}, 1'b1, "foreign addr nack");
      put_byte(8'h11, 1'b1, "ignored byte nack");
      u_bus_master_model.stop_c();
      chk("wiper kept", {1'b0, w0}, {1'b0, WIPER});
    end
  endtask : t_nack

  // Stop, then repeated start, in the middle of a data byte
  task automatic t_abort();
    logic       s;
    logic [6:0] w0;
    w0 = WIPER;
    for (int k = 0; k < 2; k++) begin
      u_bus_master_model.start_c();
      put_byte({wiper_pkg::TARGET_ADDR, 1'b0}, 1'b0, "addr ack");
      for (int i = 0; i < 7; i++) u_bus_master_model.clk_bit(1'b0, s);
      if (k == 0) u_bus_master_model.stop_c();
      else u_bus_master_model.start_c();
      chk("wiper after abort", {1'b0, w0}, {1'b0, WIPER});
    end
    put_byte({wiper_pkg::TARGET_ADDR, 1'b0}, 1'b0, "addr after restart");
    put_byte(8'h33, 1'b0, "data ack");
    u_bus_master_model.stop_c();
    chk("wiper after restart", 8'h33, {1'b0, WIPER});
  endtask : t_abort

  // A short clock spike mid byte must not count as a bit
  task automatic t_glitch();
    logic       s;
    u_bus_master_model.start_c();
    put_byte({wiper_pkg::TARGET_ADDR, 1'b0}, 1'b0, "addr ack");
    for (int i = 7; i >= 4; i--) u_bus_master_model.clk_bit(i % 2 == 0, s);
    u_bus_master_model.spike_scl();
    for (int i = 3; i >= 0; i--) u_bus_master_model.clk_bit(i % 2 == 0, s);
    u_bus_master_model.clk_bit(1'b1, s);
    chk("ack after spike", 8'h00, {7'h00, s});
    u_bus_master_model.stop_c();
    chk("wiper after spike", 8'h55, {1'b0, WIPER});
  endtask : t_glitch

  // Master forces low a bit the device leaves high; device must drop out
  task automatic t_collide();
    logic [7:0] g;
    logic       a;
    u_bus_master_model.start_c();
    put_byte({wiper_pkg::TARGET_ADDR, 1'b1}, 1'b0, "read addr ack");
    u_bus_master_model.xfer(8'hbf, 1'b1, g, a);
    chk("read after collision", 8'h3f, g);
    u_bus_master_model.stop_c();
  endtask : t_collide

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    RESETN = 1'b0;
    repeat (2) @(posedge CLK);
    #1 RESETN = 1'b1;
    repeat (10) @(posedge CLK);
    // Keeps every later link edge off the sampling edge of CLK
    #1;
    chk("wiper reset", {1'b0, wiper_pkg::WIPER_RST}, {1'b0, WIPER});
    t_write(8'h95);
    u_bus_master_model.q_ns = 2500.0;
    t_write(8'h80);
    u_bus_master_model.q_ns = 625.0;
    t_restart(8'h2a);
    t_nack();
    t_abort();
    t_glitch();
    t_collide();
    t_restart(8'h7f);
    summarize();
  end

  // Whole sequence needs about 0.9 ms of link traffic
  initial begin
    #1000us;
    err_total++;
    summarize();
  end
endmodule : i2c_slave_wiper_port_bench
`default_nettype wire
